//--- src/sepp_top.sv
// Slave-mode and run-time programming controller for an on-chip EPROM array.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module sepp_top #(
  parameter bit LARGE        = 1'b1,
  parameter int SAFETY_LIMIT = sepp_pkg::SAFETY_DEF
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RESET,
  input  wire logic                 I_SLAVE_MODE,
  input  wire logic [3:0]           I_SLAVE_INDEX,
  input  wire logic                 I_COMMAND_LATCH_STROBE,
  input  wire logic                 I_PROGRAM_STROBE_N,
  input  wire logic [15:0]          I_PORT,
  input  wire sepp_pkg::sepp_rt_bus_t I_RT,
  output logic [15:0]               O_PORT,
  output logic [15:0]               O_PORT_OE,
  output logic                      O_VERIFY_OK_OUT,
  output logic                      O_PULSE_OVERFLOW_N,
  output logic                      O_PROGRAMMING,
  output logic [15:0]               O_RT_RDATA,
  output logic                      O_LOCKED
);

  localparam int CNT_W = 16;

  typedef struct packed {
    logic [2:0]            ale_sync;
    logic [2:0]            program_strobe_n_sync;
    logic [15:0]           port_s1;
    logic [15:0]           port_s2;
    logic                  ale_q;
    logic                  program_strobe_n_n_q;
    sepp_pkg::sepp_state_t st;
    logic [1:0]            action;
    logic [13:0]           caddr;
    logic [15:0]           wdata;
    logic [CNT_W-1:0]      cnt;
    logic                  state_en;
    logic                  verify_ok;
    logic                  overflow_n;
    logic                  rt_active;
    logic [13:0]           rt_idx;
    logic [15:0]           rt_data;
    logic [15:0]           rdata;
    logic [7:0]            cfg_live;
    logic [7:0]            cfg_pend_n;
    logic                  started;
    sepp_pkg::sepp_port_drv_t drv;
  } sepp_regs_t;

  // The pending config byte is held inverted, so the all-zero power-up state reads as an erased byte.
  sepp_regs_t   r = '0;
  sepp_regs_t   next_r;
  logic [15:0]  mem [0:sepp_pkg::MEM_WORDS-1];
  logic         mem_we;
  logic [13:0]  mem_widx;
  logic [15:0]  mem_wval;
  logic [13:0]  rd_idx;
  logic [15:0]  mem_rd;

  // Maps an EPROM byte address onto the array word index; bit 12 picks the upper 8K bytes.
  function automatic logic [13:0] word_idx(input logic [15:0] a);
    logic [15:0] off;
    off = a - sepp_pkg::EPROM_BASE;
    return off[14:1];
  endfunction

  function automatic logic in_array(input logic [15:0] a);
    logic [15:0] top;
    top = LARGE ? sepp_pkg::EPROM_TOP_LARGE : sepp_pkg::EPROM_TOP_SMALL;
    return (a >= sepp_pkg::EPROM_BASE) && (a <= top) && (a[15:1] != sepp_pkg::JUMP_SELF_ADDR[15:1]);
  endfunction

  // Array cells only ever lose ones, as a real EPROM does under a pulse.
  always_ff @(posedge I_CLK) begin
    if (mem_we) begin
      mem[mem_widx] <= mem[mem_widx] & mem_wval;
    end
  end

  assign rd_idx = r.rt_active ? r.rt_idx : r.caddr;
  assign mem_rd = mem[rd_idx];

  always_comb begin
    logic ale_rise;
    logic program_strobe_n_fall;
    logic program_strobe_n_rise;
    logic ale_lvl;
    logic program_strobe_n_lvl;
    logic locked;
    logic rt_hit;
    logic [13:0] cmd_addr;
    next_r   = r;
    mem_we   = 1'b0;
    mem_widx = r.caddr;
    mem_wval = r.wdata;
    next_r.ale_sync  = {r.ale_sync[1:0], I_COMMAND_LATCH_STROBE};
    next_r.program_strobe_n_sync = {r.program_strobe_n_sync[1:0], I_PROGRAM_STROBE_N};
    next_r.port_s1   = I_PORT;
    next_r.port_s2   = r.port_s1;
    // A level is trusted only once the second and third stages agree.
    ale_lvl  = (r.ale_sync[1] == r.ale_sync[2]) ? r.ale_sync[2] : r.ale_q;
    program_strobe_n_lvl = (r.program_strobe_n_sync[1] == r.program_strobe_n_sync[2]) ? r.program_strobe_n_sync[2] : r.program_strobe_n_n_q;
    next_r.ale_q    = ale_lvl;
    next_r.program_strobe_n_n_q = program_strobe_n_lvl;
    ale_rise  = ale_lvl & ~r.ale_q;
    program_strobe_n_fall = ~program_strobe_n_lvl & r.program_strobe_n_n_q;
    program_strobe_n_rise = program_strobe_n_lvl & ~r.program_strobe_n_n_q;
    next_r.state_en = ~r.state_en;
    locked = ~r.cfg_live[sepp_pkg::WR_LOCK_BIT] | ~r.cfg_live[sepp_pkg::RD_LOCK_BIT];
    // On the large part the low action bit is also the address MSB.
    cmd_addr = LARGE ? {r.port_s2[14], r.port_s2[12:0]} : {1'b0, r.port_s2[12:0]};
    if (!r.started) begin
      next_r.started  = 1'b1;
      next_r.cfg_live = ~r.cfg_pend_n;
    end

    case (r.st)
      sepp_pkg::SEPP_ST_IDLE: begin
        next_r.drv.oe = 16'h0000;
        if (I_SLAVE_MODE && ale_rise) begin
          next_r.action = r.port_s2[sepp_pkg::CMD_HI:sepp_pkg::CMD_LO];
          next_r.caddr  = cmd_addr;
          next_r.st     = sepp_pkg::SEPP_ST_CMD;
        end
      end
      sepp_pkg::SEPP_ST_CMD: begin
        if (ale_rise) begin
          next_r.action = r.port_s2[sepp_pkg::CMD_HI:sepp_pkg::CMD_LO];
          next_r.caddr  = cmd_addr;
        end else if (program_strobe_n_fall) begin
          next_r.cnt = '0;
          case (r.action)
            sepp_pkg::SEPP_ACT_PLOW,
            sepp_pkg::SEPP_ACT_PHIGH: begin
              next_r.wdata = r.port_s2;
              if (r.action == sepp_pkg::SEPP_ACT_PHIGH && !LARGE) begin
                next_r.st = sepp_pkg::SEPP_ST_IDLE;
              end else if (locked) begin
                next_r.st = sepp_pkg::SEPP_ST_IDLE;
              end else begin
                next_r.st = sepp_pkg::SEPP_ST_DELAY;
              end
            end
            sepp_pkg::SEPP_ACT_VERIFY: begin
              if (!locked) begin
                next_r.drv.out = 16'h0000;
                next_r.drv.out[I_SLAVE_INDEX] = r.verify_ok;
                next_r.drv.oe = 16'h0000;
                next_r.drv.oe[I_SLAVE_INDEX] = 1'b1;
                next_r.st = sepp_pkg::SEPP_ST_DRIVE;
              end else begin
                next_r.st = sepp_pkg::SEPP_ST_IDLE;
              end
            end
            default: begin
              next_r.drv.out = mem_rd;
              next_r.drv.oe  = 16'hFFFF;
              next_r.st      = sepp_pkg::SEPP_ST_DRIVE;
            end
          endcase
        end
      end
      sepp_pkg::SEPP_ST_DELAY: begin
        if (program_strobe_n_rise) begin
          next_r.verify_ok  = 1'b0;
          next_r.overflow_n = 1'b1;
          next_r.st         = sepp_pkg::SEPP_ST_IDLE;
        end else if (r.state_en) begin
          next_r.cnt = r.cnt + 16'h0001;
          if (r.cnt == 16'(sepp_pkg::PROGRAM_STROBE_N_DELAY_STATES - 1)) begin
            next_r.cnt = '0;
            next_r.st  = sepp_pkg::SEPP_ST_PULSE;
          end
        end
      end
      sepp_pkg::SEPP_ST_PULSE: begin
        mem_we = 1'b1;
        if (program_strobe_n_rise) begin
          next_r.verify_ok  = (mem_rd & r.wdata) == r.wdata;
          next_r.overflow_n = 1'b1;
          next_r.st         = sepp_pkg::SEPP_ST_IDLE;
        end else if (r.state_en) begin
          next_r.cnt = r.cnt + 16'h0001;
          if (r.cnt == 16'(SAFETY_LIMIT - 1)) begin
            next_r.overflow_n = 1'b0;
            next_r.verify_ok  = (mem_rd & r.wdata) == r.wdata;
            next_r.st         = sepp_pkg::SEPP_ST_IDLE;
          end
        end
        if (r.caddr == word_idx(sepp_pkg::CONFIG_ADDR)) begin
          next_r.cfg_pend_n = r.cfg_pend_n | ~r.wdata[7:0];
        end
      end
      sepp_pkg::SEPP_ST_DRIVE: begin
        if (program_strobe_n_rise) begin
          next_r.drv.oe = 16'h0000;
          next_r.st     = sepp_pkg::SEPP_ST_IDLE;
        end
      end
      default: begin
        next_r.st = sepp_pkg::SEPP_ST_IDLE;
      end
    endcase

    // Run-time path: a write starts a pulse that the next array access ends.
    rt_hit = in_array(I_RT.addr);
    if (!I_SLAVE_MODE) begin
      if (r.rt_active) begin
        mem_we   = 1'b1;
        mem_widx = r.rt_idx;
        mem_wval = r.rt_data;
      end
      if (rt_hit && (I_RT.wr || I_RT.rd || I_RT.fetch)) begin
        next_r.rt_active = 1'b0;
        if (I_RT.rd || I_RT.fetch) begin
          next_r.rdata = mem[word_idx(I_RT.addr)];
        end
      end
      if (rt_hit && I_RT.wr && r.cfg_live[sepp_pkg::WR_LOCK_BIT]) begin
        next_r.rt_active = 1'b1;
        next_r.rt_idx    = word_idx(I_RT.addr);
        next_r.rt_data   = I_RT.wdata;
        if (word_idx(I_RT.addr) == word_idx(sepp_pkg::CONFIG_ADDR)) begin
          next_r.cfg_pend_n = r.cfg_pend_n | ~I_RT.wdata[7:0];
        end
      end
    end else begin
      next_r.rt_active = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      r            <= '0;
      r.ale_sync   <= 3'h0;
      r.program_strobe_n_sync  <= 3'h7;
      r.program_strobe_n_n_q   <= 1'b1;
      r.st         <= sepp_pkg::SEPP_ST_IDLE;
      r.verify_ok  <= 1'b1;
      r.overflow_n <= 1'b1;
      r.cfg_live   <= sepp_pkg::CONFIG_RESET;
      r.cfg_pend_n <= r.cfg_pend_n;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_PORT             <= 16'h0000;
      O_PORT_OE          <= 16'h0000;
      O_VERIFY_OK_OUT    <= 1'b1;
      O_PULSE_OVERFLOW_N <= 1'b1;
      O_PROGRAMMING      <= 1'b0;
      O_RT_RDATA         <= 16'h0000;
      O_LOCKED           <= 1'b0;
    end else begin
      O_PORT             <= next_r.drv.out;
      O_PORT_OE          <= next_r.drv.oe;
      O_VERIFY_OK_OUT    <= next_r.verify_ok;
      O_PULSE_OVERFLOW_N <= next_r.overflow_n;
      O_PROGRAMMING      <= (next_r.st == sepp_pkg::SEPP_ST_PULSE) | next_r.rt_active;
      O_RT_RDATA         <= next_r.rdata;
      O_LOCKED           <= ~next_r.cfg_live[sepp_pkg::WR_LOCK_BIT] | ~next_r.cfg_live[sepp_pkg::RD_LOCK_BIT];
    end
  end

endmodule

`default_nettype wire

//--- src/sepp_pkg.sv
// Package with constants, state encodings and carrier structs of the slave EPROM programming port.
package sepp_pkg;

  localparam int          ADDR_W          = 14;
  localparam int          DATA_W          = 16;
  localparam int          MEM_WORDS       = 16384;
  localparam logic [15:0] EPROM_BASE      = 16'h2000;
  localparam logic [15:0] EPROM_TOP_SMALL = 16'h3FFF;
  localparam logic [15:0] EPROM_TOP_LARGE = 16'h5FFF;
  localparam logic [15:0] JUMP_SELF_ADDR  = 16'h201A;
  localparam logic [15:0] CONFIG_ADDR     = 16'h2018;
  localparam int          CMD_HI          = 15;
  localparam int          CMD_LO          = 14;
  localparam int          SLAVE_IDX_W     = 4;
  localparam int          PROGRAM_STROBE_N_DELAY_STATES = 48;
  localparam int          CLK_MHZ         = 25;
  localparam int          STATE_CLKS      = 2;
  localparam int          STATE_NS        = 1000 * STATE_CLKS / CLK_MHZ;
  localparam int          SAFETY_DEF      = 2600;
  localparam logic [7:0]  CONFIG_RESET    = 8'hFF;
  localparam int          WR_LOCK_BIT     = 0;
  localparam int          RD_LOCK_BIT     = 1;
  localparam logic [15:0] ERASED_WORD     = 16'hFFFF;

  typedef enum logic [1:0] {
    SEPP_ACT_DUMP   = 2'b00,
    SEPP_ACT_VERIFY = 2'b01,
    SEPP_ACT_PLOW   = 2'b10,
    SEPP_ACT_PHIGH  = 2'b11
  } sepp_action_t;

  typedef enum logic [4:0] {
    SEPP_ST_IDLE  = 5'b00001,
    SEPP_ST_CMD   = 5'b00010,
    SEPP_ST_DELAY = 5'b00100,
    SEPP_ST_PULSE = 5'b01000,
    SEPP_ST_DRIVE = 5'b10000
  } sepp_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        fetch;
  } sepp_rt_bus_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } sepp_port_drv_t;

endpackage

//--- test/sepp_sva.sv
// Concurrent checks on the pins of the slave EPROM programming port.
`timescale 1ns/1ns
`default_nettype none
module sepp_sva #(
  parameter bit LARGE        = 1'b1,
  parameter int SAFETY_LIMIT = 20
) (
  input wire logic                   I_CLK,
  input wire logic                   I_RESET,
  input wire logic                   I_SLAVE_MODE,
  input wire logic [3:0]             I_SLAVE_INDEX,
  input wire logic                   I_PROGRAM_STROBE_N,
  input wire sepp_pkg::sepp_rt_bus_t I_RT,
  input wire logic [15:0]            O_PORT,
  input wire logic [15:0]            O_PORT_OE,
  input wire logic                   O_VERIFY_OK_OUT,
  input wire logic                   O_PROGRAMMING,
  input wire logic                   O_LOCKED
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  logic [15:0] low_cnt;
  logic [15:0] program_strobe_n_cnt;
  logic        in_arr;
  // The jump-to-self word sits inside the address range but is not array.
  assign in_arr = I_RT.addr >= 16'h2000 && I_RT.addr <= (LARGE ? 16'h5FFF : 16'h3FFF) && I_RT.addr[15:1] != 15'h100D;
  always_ff @(posedge I_CLK) begin
    low_cnt  <= I_PROGRAM_STROBE_N ? 16'h0000 : low_cnt + 16'h0001;
    program_strobe_n_cnt <= O_PROGRAMMING ? program_strobe_n_cnt + 16'h0001 : 16'h0000;
  end
  sequence s_strobe_rise;
    $rose(I_PROGRAM_STROBE_N) && I_SLAVE_MODE;
  endsequence
  a_oe_release: assert property (s_strobe_rise |-> ##[1:8] O_PORT_OE == 16'h0000)
    else $error("port still driven after strobe rise");
  a_lane_one_bit: assert property (|O_PORT_OE |-> O_PORT_OE == 16'hFFFF || O_PORT_OE == 16'h0001 << I_SLAVE_INDEX)
    else $error("port drive outside the slave lane");
  a_lane_value: assert property (|O_PORT_OE && O_PORT_OE != 16'hFFFF |-> O_PORT[I_SLAVE_INDEX] == O_VERIFY_OK_OUT)
    else $error("verify lane value differs from verify result");
  a_program_strobe_n_start_delay: assert property ($rose(O_PROGRAMMING) && I_SLAVE_MODE |-> low_cnt inside {[16'h0061:16'h0068]})
    else $error("pulse start not 48 states after strobe fall");
  a_pulse_end: assert property (s_strobe_rise |-> ##[1:8] !O_PROGRAMMING)
    else $error("pulse outlives strobe rise");
  a_safety_bound: assert property (O_PROGRAMMING && I_SLAVE_MODE |-> program_strobe_n_cnt <= 2 * SAFETY_LIMIT + 4)
    else $error("pulse exceeds safety limit");
  a_rt_write_starts: assert property (!I_SLAVE_MODE && I_RT.wr && in_arr && !O_LOCKED |=> O_PROGRAMMING)
    else $error("array write did not start programming");
  a_rt_read_stops: assert property (!I_SLAVE_MODE && O_PROGRAMMING && (I_RT.rd || I_RT.fetch) && !I_RT.wr && in_arr
                                    |=> !O_PROGRAMMING)
    else $error("array access did not end programming");
  a_jump_self_kept: assert property (!I_SLAVE_MODE && O_PROGRAMMING && I_RT.fetch && !I_RT.rd && !I_RT.wr
                                     && I_RT.addr[15:1] == 15'h100D |=> O_PROGRAMMING)
    else $error("jump-to-self fetch ended programming");
  a_lock_refuses: assert property (O_LOCKED && I_SLAVE_MODE |-> !O_PROGRAMMING)
    else $error("locked device programs");
endmodule
bind sepp_top sepp_sva #(.LARGE(LARGE), .SAFETY_LIMIT(SAFETY_LIMIT)) i_sepp_sva (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_SLAVE_MODE(I_SLAVE_MODE), .I_SLAVE_INDEX(I_SLAVE_INDEX),
  .I_PROGRAM_STROBE_N(I_PROGRAM_STROBE_N), .I_RT(I_RT), .O_PORT(O_PORT), .O_PORT_OE(O_PORT_OE),
  .O_VERIFY_OK_OUT(O_VERIFY_OK_OUT), .O_PROGRAMMING(O_PROGRAMMING), .O_LOCKED(O_LOCKED));
`default_nettype wire

//--- test/sepp_master.sv
// Behavioural master programmer driving commands and data into the slave port.
`timescale 1ns/1ns
`default_nettype none
module sepp_master (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_drv,
  input  wire logic [15:0] i_oe,
  output logic             o_latch,
  output logic             o_program_strobe_n_n,
  output logic [15:0]      o_bus
);
  logic [15:0] mdata;
  logic        mdrive;
  // Released lines float up to the board pull-ups, never to the last value.
  assign o_bus = (i_oe & i_drv) | (~i_oe & (mdrive ? mdata : 16'hFFFF));
  initial begin
    o_latch  = 1'b0;
    o_program_strobe_n_n = 1'b1;
    mdrive   = 1'b0;
    mdata    = 16'h0000;
  end
  // One latch pulse then one strobe pulse, so the two kinds always alternate.
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] data, input int hold, output logic [15:0] seen);
    @(posedge i_clk);
    mdrive  <= 1'b1;
    mdata   <= cmd;
    o_latch <= 1'b1;
    repeat (5) @(posedge i_clk);
    o_latch <= 1'b0;
    repeat (5) @(posedge i_clk);
    mdata    <= data;
    mdrive   <= cmd[15];
    o_program_strobe_n_n <= 1'b0;
    repeat (hold) @(posedge i_clk);
    seen     = o_bus;
    o_program_strobe_n_n <= 1'b1;
    mdrive   <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

//--- test/slave_eprom_programming_port_bench.sv
// Self-checking bench for the slave EPROM programming port.
`timescale 1ns/1ns
`default_nettype none
module slave_eprom_programming_port_bench;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] data;
    logic [3:0]  idx;
    logic [15:0] hold;
    logic        ok;
    logic        ovf_n;
  } sepp_row_t;
  // The pulse opens about 100 cycles into the strobe; 200 overruns the limit.
  // Each row uses its own slave index, as a gang of distinct slaves would.
  sepp_row_t rows [4] = '{'{16'h8010, 16'h0000, 4'h3, 16'h006E, 1'b1, 1'b1},
                          '{16'h8010, 16'hFFFF, 4'hA, 16'h006E, 1'b0, 1'b1},
                          '{16'hC010, 16'h0000, 4'h0, 16'h006E, 1'b1, 1'b1},
                          '{16'h8020, 16'h0000, 4'hF, 16'h00C8, 1'b1, 1'b0}};
  logic clk, rst, mode, latch, program_strobe_n_n, vok, ovf_n, pgm, locked;
  logic [3:0]  sidx;
  logic [15:0] bus, port, oe, rdata, seen;
  logic [34:0] rt;
  int          n_fail, tests_run, cycles;
  sepp_top #(.LARGE(1'b1), .SAFETY_LIMIT(20)) i_sepp_top (.I_CLK(clk), .I_RESET(rst), .I_SLAVE_MODE(mode),
    .I_SLAVE_INDEX(sidx), .I_COMMAND_LATCH_STROBE(latch), .I_PROGRAM_STROBE_N(program_strobe_n_n), .I_PORT(bus), .I_RT(rt),
    .O_PORT(port), .O_PORT_OE(oe), .O_VERIFY_OK_OUT(vok), .O_PULSE_OVERFLOW_N(ovf_n), .O_PROGRAMMING(pgm),
    .O_RT_RDATA(rdata), .O_LOCKED(locked));
  sepp_master i_sepp_master (.i_clk(clk), .i_drv(port), .i_oe(oe), .o_latch(latch), .o_program_strobe_n_n(program_strobe_n_n), .o_bus(bus));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rt_op(input logic [15:0] a, input logic [15:0] d, input logic [2:0] k);
    @(posedge clk);
    rt <= {a, d, k};
    @(posedge clk);
    rt <= '0;
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    rst  = 1'b1;
    mode = 1'b1;
    sidx = 4'h0;
    rt   = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    chk("reset_oe", oe, 16'h0000);
    chk("reset_vok", {15'h0000, vok}, 16'h0001);
    chk("reset_ovf", {15'h0000, ovf_n}, 16'h0001);
    chk("reset_lock", {15'h0000, locked}, 16'h0000);
    for (int r = 0; r < 4; r++) begin
      sidx <= rows[r].idx;
      i_sepp_master.xfer(rows[r].cmd, rows[r].data, int'(rows[r].hold), seen);
      chk("verify_ok", {15'h0000, vok}, {15'h0000, rows[r].ok});
      chk("overflow_n", {15'h0000, ovf_n}, {15'h0000, rows[r].ovf_n});
      i_sepp_master.xfer(16'h4000, 16'h0000, 20, seen);
      chk("lane", seen, 16'hFFFF ^ ({15'h0000, ~rows[r].ok} << rows[r].idx));
    end
    i_sepp_master.xfer(16'h0010, 16'h0000, 20, seen);
    chk("dump", seen, 16'h0000);
    mode <= 1'b0;
    rt_op(16'h2100, 16'h0000, 3'b100);
    chk("rt_start", {15'h0000, pgm}, 16'h0001);
    rt_op(16'h201A, 16'h0000, 3'b001);
    chk("jump_self", {15'h0000, pgm}, 16'h0001);
    rt_op(16'h2100, 16'h0000, 3'b001);
    chk("fetch_stop", {15'h0000, pgm}, 16'h0000);
    chk("rt_rdata", rdata, 16'h0000);
    // Software times each pulse itself: 25 write/read pairs, verified only after the last.
    for (int p = 0; p < 25; p++) begin
      rt_op(16'h2200, 16'h0000, 3'b100);
      rt_op(16'h2200, 16'h0000, 3'b010);
    end
    chk("multi_pulse", rdata, 16'h0000);
    rt_op(16'h2018, 16'h0000, 3'b100);
    rt_op(16'h2018, 16'h0000, 3'b010);
    chk("read_stop", {15'h0000, pgm}, 16'h0000);
    chk("lock_late", {15'h0000, locked}, 16'h0000);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    chk("locked", {15'h0000, locked}, 16'h0001);
    rt_op(16'h2100, 16'h0000, 3'b100);
    chk("lock_refuse", {15'h0000, pgm}, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
